// file: src/dac_seq_pkg.sv
// Package: constants, types and timing for the four-channel sequencer
package dac_seq_pkg;
  localparam int CLK_MHZ = 25;
  localparam int NCH = 4;
  localparam int CODE_W = 12;
  // Step period per selector code, in units of 10 ns (figure x 100 for integer form)
  localparam int STEP_TIME_10NS [16] = '{0, 400, 800, 1200, 1800, 2704, 4048, 6072,
    9112, 13672, 23920, 41864, 73256, 128200, 256396, 512792};
  // Cycles per 10 ns unit at 25 MHz: cycles = t_10ns * 25 / 100, rounded down
  localparam int STEP_SIZE [8] = '{1, 2, 3, 4, 6, 8, 16, 32};
  localparam logic [7:0] OP_OFF = 8'h00;
  localparam logic [7:0] OP_ON = 8'h80;
  localparam logic [7:0] OP_MARGIN_LO = 8'h94;
  localparam logic [7:0] OP_MARGIN_HI = 8'hA4;
  localparam logic [2:0] WAVE_TRI = 3'b000;
  localparam logic [2:0] WAVE_SAW_UP = 3'b001;
  localparam logic [2:0] WAVE_SAW_DN = 3'b010;
  localparam logic [2:0] WAVE_SINE = 3'b100;
  localparam logic [3:0] RESET_KEY = 4'b1010;
  localparam logic [3:0] UNLOCK_KEY = 4'b0101;
  localparam int SINE_PTS = 24;
  localparam int PHASE_IDX [4] = '{0, 6, 8, 16};
  localparam logic [11:0] SINE_TAB [24] = '{12'h800, 12'h9A8, 12'hB33, 12'hC87,
    12'hD8B, 12'hE2F, 12'hE66, 12'hE2F, 12'hD8B, 12'hC87, 12'hB33, 12'h9A8,
    12'h800, 12'h658, 12'h4CD, 12'h379, 12'h275, 12'h1D1, 12'h19A, 12'h1D1,
    12'h275, 12'h379, 12'h4CD, 12'h658};
  localparam logic [7:0] PROTO_REV_DEFAULT = 8'h22;
  localparam int BOOT_US = 1;
  localparam int BOOT_CYC = BOOT_US * CLK_MHZ;
  localparam int TIMEOUT_US = 25000;
  localparam logic [15:0] PAGE_ALL = 16'h00FF;

  typedef enum logic [1:0] {MODE_OFF, MODE_ON, MODE_MLO, MODE_MHI} ch_mode_e;

  // Per-channel configuration as loaded from nonvolatile memory or written
  typedef struct packed {
    logic [11:0] margin_hi;
    logic [11:0] margin_lo;
    logic [3:0] step_period;
    logic [2:0] step_size;
    logic [2:0] waveform_select;
    logic [1:0] phase_sel;
    logic wave_en;
  } ch_cfg_s;

  // A register write from the serial engine
  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
    logic [15:0] data;
  } bus_wr_s;
endpackage

// file: src/dac_channel_sequencer.sv
// Operation commands, waveform generators and reset/lock handling, four channels
`timescale 1ns/1ps
// Summary of operation
// - Command reads return the data low byte first, after a repeated start.
// - Bus commands are accepted only when the protocol enable bit is one.
// - Step period selector sets update interval; zero means immediate change.
// - Step size selector moves 1,2,3,4,6,8,16 or 32 LSBs per update.
// - Operation code 00h turns output off, 80h turns it on.
// - Codes 94h/A4h step output toward margin-low/high at set size and period.
// - Page register steers following channel-specific accesses to one channel, or to all four at FFh.
// - Group commands supported; bus timeouts detected as failures.
// - Communication fault flag sets on fault, clears by writing one or when boot loads defaults.
// - Read-only protocol revision register readable by the host.
// - Each channel runs its own independent waveform generator.
// - Select 000 gives triangle between margin-low and margin-high.
// - Select 001 rising sawtooth, 010 falling sawtooth.
// - Select 100 gives 24-point sine, one point per step period.
// - Sine table holds 24 fixed 12-bit codes, 0x800 to 0xE66 to 0x19A.
// - Sine start phase 0/90/120/240 degrees starts at index 0/6/8/16.
// - Power-on reset loads defaults from nonvolatile memory; host waits boot delay.
// - Reset code 1010b in trigger register acts as a power-on reset.
// - Reset pin falling edge starts boot; rising edge ignored.
// - Write lock set makes the device ignore all register writes except the reset and unlock codes in the trigger register.
// - Software reset still works while write lock is set.
// - Unlock key 0101b in trigger register overrides the write lock.
module dac_channel_sequencer #(
  parameter int TIMEOUT_CYC = dac_seq_pkg::TIMEOUT_US * dac_seq_pkg::CLK_MHZ
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Decoded bus traffic from the serial engine (same clock)
  input wire dac_seq_pkg::bus_wr_s bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [7:0] bus_rd_cmd_in,
  input wire logic bus_fault_in,
  input wire logic bus_active_in,
  input wire logic group_stop_in,
  // Link clock from the host, sampled for timeout detection
  input wire logic link_clk_in,
  // Configuration straps and pins
  input wire logic protocol_en_in,
  input wire logic pin_is_reset_in,
  input wire logic reset_pin_n_in,
  input wire dac_seq_pkg::ch_cfg_s [3:0] nvm_cfg_in,
  input wire logic write_lock_in,
  // Status and outputs
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  output logic comm_fault_flag_out,
  output logic booting_out,
  output logic lock_active_out,
  output logic [3:0] ch_on_out,
  output logic [3:0][11:0] ch_code_out
);
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_OPER = 8'h01;
  localparam logic [7:0] CMD_CML = 8'h7E;
  localparam logic [7:0] CMD_REV = 8'h98;
  localparam logic [7:0] CMD_TRIG = 8'hD0;
  localparam logic [7:0] CMD_FCFG = 8'hD1;

  // Step length in clock cycles, rounded down, at least one
  function automatic logic [17:0] step_cycles(input logic [3:0] sel);
    int c;
    c = dac_seq_pkg::STEP_TIME_10NS[sel] * dac_seq_pkg::CLK_MHZ / 100;
    return (c < 1) ? 18'd1 : 18'(c);
  endfunction

  function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [6:0] b,
                                          input logic [11:0] lim);
    logic [12:0] s;
    s = {1'b0, a} + {6'd0, b};
    return (s >= {1'b0, lim}) ? lim : s[11:0];
  endfunction

  function automatic logic [11:0] sat_sub(input logic [11:0] a, input logic [6:0] b,
                                          input logic [11:0] lim);
    logic [12:0] s;
    s = {1'b0, a} - {6'd0, b};
    return (s[12] || s[11:0] <= lim) ? lim : s[11:0];
  endfunction

  // Synchronisers for pins outside the clock domain
  logic [1:0] rst_pin_sync_r;
  logic [1:0] link_sync_r;
  logic rst_pin_prev_r;
  logic link_prev_r;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_pin_sync_r <= 2'b11;
      link_sync_r <= 2'b11;
      rst_pin_prev_r <= 1'b1;
      link_prev_r <= 1'b1;
    end else begin
      rst_pin_sync_r <= {rst_pin_sync_r[0], reset_pin_n_in};
      link_sync_r <= {link_sync_r[0], link_clk_in};
      rst_pin_prev_r <= rst_pin_sync_r[1];
      link_prev_r <= link_sync_r[1];
    end
  end
  logic pin_fall;
  logic link_edge;
  assign pin_fall = pin_is_reset_in && rst_pin_prev_r && !rst_pin_sync_r[1];
  assign link_edge = link_sync_r[1] != link_prev_r;

  // Bus access qualification; trigger write handled ahead of the lock
  logic wr_ok;
  logic lock_r, lock_nxt;
  logic wl_prev_r;
  logic soft_rst;
  logic unlock_hit;
  assign wr_ok = bus_wr_in.valid && protocol_en_in;
  assign soft_rst = wr_ok && bus_wr_in.cmd == CMD_TRIG &&
                    bus_wr_in.data[3:0] == dac_seq_pkg::RESET_KEY;
  assign unlock_hit = wr_ok && bus_wr_in.cmd == CMD_TRIG &&
                      bus_wr_in.data[7:4] == dac_seq_pkg::UNLOCK_KEY;
  logic wr_en;
  assign wr_en = wr_ok && !lock_r && !booting_out;

  // Boot sequencer: power-on, software and pin reset share one path
  logic [15:0] boot_cnt_r, boot_cnt_nxt;
  logic boot_start;
  assign boot_start = soft_rst || pin_fall;
  always_comb begin
    boot_cnt_nxt = boot_cnt_r;
    if (boot_start) begin
      boot_cnt_nxt = 16'(dac_seq_pkg::BOOT_CYC);
    end else if (boot_cnt_r != 16'd0) begin
      boot_cnt_nxt = boot_cnt_r - 16'd1;
    end
    // Lock arms on a rising lock bit; the key keeps it open until re-armed
    lock_nxt = lock_r;
    if (!write_lock_in) begin
      lock_nxt = 1'b0;
    end else if (unlock_hit) begin
      lock_nxt = 1'b0;
    end else if (!wl_prev_r) begin
      lock_nxt = 1'b1;
    end
  end
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      boot_cnt_r <= 16'(dac_seq_pkg::BOOT_CYC);
      lock_r <= 1'b0;
      wl_prev_r <= 1'b0;
    end else begin
      boot_cnt_r <= boot_cnt_nxt;
      lock_r <= lock_nxt;
      wl_prev_r <= write_lock_in;
    end
  end
  assign booting_out = boot_cnt_r != 16'd0;
  assign lock_active_out = lock_r;
  logic load_defaults;
  assign load_defaults = boot_cnt_r == 16'd1;

  // Page, fault flag, link-timeout counter
  logic [7:0] page_r, page_nxt;
  logic fault_r, fault_nxt;
  logic [31:0] to_cnt_r, to_cnt_nxt;
  logic timeout;
  assign timeout = bus_active_in && to_cnt_r >= 32'(TIMEOUT_CYC - 1);
  always_comb begin
    page_nxt = page_r;
    fault_nxt = fault_r;
    to_cnt_nxt = (bus_active_in && !link_edge) ? to_cnt_r + 32'd1 : 32'd0;
    if (wr_en && bus_wr_in.cmd == CMD_PAGE) begin
      page_nxt = bus_wr_in.data[7:0];
    end
    if (wr_en && bus_wr_in.cmd == CMD_CML && bus_wr_in.data[1]) begin
      fault_nxt = 1'b0;
    end
    if (bus_fault_in || timeout) begin
      fault_nxt = 1'b1; // set beats clear
    end
    if (load_defaults) begin
      page_nxt = 8'd0;
      fault_nxt = 1'b0;
    end
  end
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      page_r <= 8'd0;
      fault_r <= 1'b0;
      to_cnt_r <= 32'd0;
    end else begin
      page_r <= page_nxt;
      fault_r <= fault_nxt;
      to_cnt_r <= to_cnt_nxt;
    end
  end
  assign comm_fault_flag_out = fault_r;

  // Readback, low byte first on the wire is done by the serial engine
  logic [15:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r;
  dac_seq_pkg::ch_cfg_s cfg_r [4];
  dac_seq_pkg::ch_cfg_s cfg_nxt [4];
  dac_seq_pkg::ch_mode_e mode_r [4];
  dac_seq_pkg::ch_mode_e mode_nxt [4];
  always_comb begin
    case (bus_rd_cmd_in)
      CMD_PAGE: rd_data_nxt = {8'd0, page_r};
      CMD_CML: rd_data_nxt = {14'd0, fault_r, 1'b0};
      CMD_REV: rd_data_nxt = {8'd0, dac_seq_pkg::PROTO_REV_DEFAULT};
      CMD_OPER: rd_data_nxt = {(page_r < 8'd4) ? (mode_r[page_r[1:0]] == dac_seq_pkg::MODE_OFF ?
                               8'h00 : 8'h80) : 8'h00, 8'h00};
      default: rd_data_nxt = 16'd0;
    endcase
  end
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_r <= 16'd0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= bus_rd_in && protocol_en_in;
      if (bus_rd_in && protocol_en_in) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end
  assign rd_data_out = rd_data_r;
  assign rd_valid_out = rd_valid_r;

  // Per-channel operation state and waveform generators
  logic [11:0] code_r [4];
  logic [11:0] code_nxt [4];
  logic [17:0] tick_r [4];
  logic [17:0] tick_nxt [4];
  logic dir_r [4];
  logic dir_nxt [4];
  logic [4:0] sidx_r [4];
  logic [4:0] sidx_nxt [4];
  logic [7:0] pend_op_r [4];
  logic [7:0] pend_op_nxt [4];
  logic pend_r [4];
  logic pend_nxt [4];
  always_comb begin
    for (int ch = 0; ch < 4; ch++) begin
      logic sel;
      logic step;
      logic [6:0] sz;
      logic [7:0] op;
      sel = page_r == 8'(ch) || page_r == dac_seq_pkg::PAGE_ALL[7:0];
      cfg_nxt[ch] = cfg_r[ch];
      mode_nxt[ch] = mode_r[ch];
      code_nxt[ch] = code_r[ch];
      dir_nxt[ch] = dir_r[ch];
      sidx_nxt[ch] = sidx_r[ch];
      pend_op_nxt[ch] = pend_op_r[ch];
      pend_nxt[ch] = pend_r[ch];
      sz = 7'(dac_seq_pkg::STEP_SIZE[cfg_r[ch].step_size]);
      step = tick_r[ch] == 18'd0;
      tick_nxt[ch] = step ? step_cycles(cfg_r[ch].step_period) - 18'd1 : tick_r[ch] - 18'd1;
      op = 8'h00;
      if (wr_en && sel && bus_wr_in.cmd == CMD_OPER) begin
        pend_op_nxt[ch] = bus_wr_in.data[15:8];
        pend_nxt[ch] = 1'b1; // group command held to stop
      end
      if (pend_r[ch] && group_stop_in) begin
        pend_nxt[ch] = 1'b0;
        op = pend_op_r[ch];
        case (op)
          dac_seq_pkg::OP_OFF: mode_nxt[ch] = dac_seq_pkg::MODE_OFF;
          dac_seq_pkg::OP_ON: mode_nxt[ch] = dac_seq_pkg::MODE_ON;
          dac_seq_pkg::OP_MARGIN_LO: mode_nxt[ch] = dac_seq_pkg::MODE_MLO;
          dac_seq_pkg::OP_MARGIN_HI: mode_nxt[ch] = dac_seq_pkg::MODE_MHI;
          default: mode_nxt[ch] = mode_r[ch];
        endcase
        sidx_nxt[ch] = 5'(dac_seq_pkg::PHASE_IDX[cfg_r[ch].phase_sel]);
      end
      if (wr_en && sel && bus_wr_in.cmd == CMD_FCFG) begin
        cfg_nxt[ch].step_period = bus_wr_in.data[3:0];
        cfg_nxt[ch].step_size = bus_wr_in.data[6:4];
        cfg_nxt[ch].waveform_select = bus_wr_in.data[10:8];
        cfg_nxt[ch].phase_sel = bus_wr_in.data[12:11];
        cfg_nxt[ch].wave_en = bus_wr_in.data[13];
      end
      if (mode_r[ch] == dac_seq_pkg::MODE_MLO || mode_r[ch] == dac_seq_pkg::MODE_MHI) begin
        logic [11:0] tgt;
        tgt = mode_r[ch] == dac_seq_pkg::MODE_MLO ? cfg_r[ch].margin_lo : cfg_r[ch].margin_hi;
        if (cfg_r[ch].step_period == 4'd0) begin
          code_nxt[ch] = tgt;
        end else if (step && code_r[ch] < tgt) begin
          code_nxt[ch] = sat_add(code_r[ch], sz, tgt);
        end else if (step && code_r[ch] > tgt) begin
          code_nxt[ch] = sat_sub(code_r[ch], sz, tgt);
        end
      end else if (mode_r[ch] == dac_seq_pkg::MODE_ON && cfg_r[ch].wave_en && step) begin
        case (cfg_r[ch].waveform_select)
          dac_seq_pkg::WAVE_TRI: begin
            if (!dir_r[ch]) begin
              code_nxt[ch] = sat_add(code_r[ch], sz, cfg_r[ch].margin_hi);
              dir_nxt[ch] = code_nxt[ch] == cfg_r[ch].margin_hi;
            end else begin
              code_nxt[ch] = sat_sub(code_r[ch], sz, cfg_r[ch].margin_lo);
              dir_nxt[ch] = code_nxt[ch] != cfg_r[ch].margin_lo;
            end
          end
          dac_seq_pkg::WAVE_SAW_UP: code_nxt[ch] = code_r[ch] >= cfg_r[ch].margin_hi ?
            cfg_r[ch].margin_lo : sat_add(code_r[ch], sz, cfg_r[ch].margin_hi);
          dac_seq_pkg::WAVE_SAW_DN: code_nxt[ch] = code_r[ch] <= cfg_r[ch].margin_lo ?
            cfg_r[ch].margin_hi : sat_sub(code_r[ch], sz, cfg_r[ch].margin_lo);
          dac_seq_pkg::WAVE_SINE: begin
            code_nxt[ch] = dac_seq_pkg::SINE_TAB[sidx_r[ch]];
            sidx_nxt[ch] = sidx_r[ch] == 5'd23 ? 5'd0 : sidx_r[ch] + 5'd1;
          end
          default: code_nxt[ch] = code_r[ch];
        endcase
      end
      if (load_defaults) begin
        cfg_nxt[ch] = nvm_cfg_in[ch];
        mode_nxt[ch] = dac_seq_pkg::MODE_OFF;
        code_nxt[ch] = nvm_cfg_in[ch].margin_lo;
        pend_nxt[ch] = 1'b0;
        dir_nxt[ch] = 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int ch = 0; ch < 4; ch++) begin
        cfg_r[ch] <= '0;
        mode_r[ch] <= dac_seq_pkg::MODE_OFF;
        code_r[ch] <= 12'h000;
        tick_r[ch] <= 18'd0;
        dir_r[ch] <= 1'b0;
        sidx_r[ch] <= 5'd0;
        pend_op_r[ch] <= 8'h00;
        pend_r[ch] <= 1'b0;
      end
    end else begin
      for (int ch = 0; ch < 4; ch++) begin
        cfg_r[ch] <= cfg_nxt[ch];
        mode_r[ch] <= mode_nxt[ch];
        code_r[ch] <= code_nxt[ch];
        tick_r[ch] <= tick_nxt[ch];
        dir_r[ch] <= dir_nxt[ch];
        sidx_r[ch] <= sidx_nxt[ch];
        pend_op_r[ch] <= pend_op_nxt[ch];
        pend_r[ch] <= pend_nxt[ch];
      end
    end
  end
  always_comb begin
    for (int ch = 0; ch < 4; ch++) begin
      ch_on_out[ch] = mode_r[ch] != dac_seq_pkg::MODE_OFF;
      ch_code_out[ch] = code_r[ch];
    end
  end

  // Assertions
  fault_sticky_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (bus_fault_in) |=> fault_r) else $error("fault flag not set");
  fault_hold_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (fault_r && !(wr_en && bus_wr_in.cmd == CMD_CML) && !load_defaults) |=> fault_r)
    else $error("fault flag dropped");
  proto_gate_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (!protocol_en_in) |=> !rd_valid_out) else $error("read without enable");
  lock_block_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (lock_r && !unlock_hit && bus_wr_in.cmd == CMD_PAGE) |=> $stable(page_r))
    else $error("write under lock");
  soft_reset_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    soft_rst |=> boot_cnt_r == 16'(dac_seq_pkg::BOOT_CYC)) else $error("soft reset lost");
  pin_reset_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    pin_fall |=> booting_out) else $error("pin reset ignored");
  sine_range_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    sidx_r[0] < 5'd24) else $error("sine index out of range");
  margin_bound_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (mode_r[0] == dac_seq_pkg::MODE_MHI && code_r[0] <= cfg_r[0].margin_hi)
    |=> code_r[0] <= cfg_r[0].margin_hi) else $error("margin overshoot");
  cov_margin_c: cover property (@(posedge core_clk_in) mode_r[0] == dac_seq_pkg::MODE_MHI);
  cov_fault_c: cover property (@(posedge core_clk_in) timeout);
  cov_soft_c: cover property (@(posedge core_clk_in) soft_rst && lock_r);
endmodule

// file: verification/pm_host_model.sv
// Host controller model: decoded bus frames and link clock
`timescale 1ns/1ps
module pm_host_model (
  // Clock
  input wire logic core_clk_in,
  // Decoded traffic towards the device
  output dac_seq_pkg::bus_wr_s bus_wr_out,
  output logic bus_rd_out,
  output logic [7:0] bus_rd_cmd_out,
  output logic bus_active_out,
  output logic group_stop_out,
  // Link clock, holds its last level between frames
  output logic link_clk_out
);
  logic stall = 1'b0;
  initial begin
    bus_wr_out = '0;
    bus_rd_out = 1'b0;
    bus_rd_cmd_out = 8'h00;
    bus_active_out = 1'b0;
    group_stop_out = 1'b0;
    link_clk_out = 1'b1;
  end
  // Runs only inside frames; offset keeps it unrelated to the core clock
  initial begin
    #7;
    forever begin
      #160;
      if (bus_active_out && !stall) link_clk_out = ~link_clk_out;
    end
  end
  // Whole 16-bit word per frame, released lines show inverted data
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge core_clk_in);
    bus_active_out = 1'b1;
    bus_wr_out = '{valid: 1'b1, cmd: c, data: d};
    @(negedge core_clk_in);
    bus_wr_out.valid = 1'b0;
    bus_wr_out.data = ~d;
    bus_active_out = 1'b0;
  endtask
  // Command read after repeated start
  task automatic rd(input logic [7:0] c);
    @(negedge core_clk_in);
    bus_active_out = 1'b1;
    bus_rd_out = 1'b1;
    bus_rd_cmd_out = c;
    @(negedge core_clk_in);
    bus_rd_out = 1'b0;
    bus_rd_cmd_out = ~c;
    bus_active_out = 1'b0;
  endtask
  // Page first, then operation code, applied at group stop
  task automatic op(input logic [7:0] page, input logic [7:0] code);
    wr(8'h00, {8'h00, page});
    wr(8'h01, {code, 8'h00});
    @(negedge core_clk_in);
    group_stop_out = 1'b1;
    @(negedge core_clk_in);
    group_stop_out = 1'b0;
  endtask
  // Long frame, link clock optionally frozen
  task automatic frame(input int n, input logic s);
    @(negedge core_clk_in);
    bus_active_out = 1'b1;
    stall = s;
    repeat (n) @(negedge core_clk_in);
    stall = 1'b0;
    bus_active_out = 1'b0;
  endtask
endmodule

// file: verification/dac_channel_sequencer_tb.sv
// Self-checking bench for the four-channel sequencer
`timescale 1ns/1ps
module dac_channel_sequencer_tb;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic bus_fault = 1'b0;
  logic protocol_en = 1'b0;
  logic pin_is_reset = 1'b0;
  logic reset_pin_n = 1'b1;
  logic write_lock = 1'b0;
  dac_seq_pkg::bus_wr_s bus_wr;
  logic bus_rd, bus_active, group_stop, link_clk, rd_valid, fault, booting, lock_act;
  logic [7:0] rd_cmd;
  logic [15:0] rd_data;
  logic [3:0] ch_on;
  logic [3:0][11:0] ch_code;
  dac_seq_pkg::ch_cfg_s [3:0] nvm_cfg;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int per;
  logic [15:0] rd_notes [$];
  logic [11:0] seen [$];
  int gaps [$];

  always #20 core_clk_in = ~core_clk_in;

  pm_host_model pm_host_model_inst (.core_clk_in(core_clk_in), .bus_wr_out(bus_wr),
    .bus_rd_out(bus_rd), .bus_rd_cmd_out(rd_cmd), .bus_active_out(bus_active),
    .group_stop_out(group_stop), .link_clk_out(link_clk));

  dac_channel_sequencer #(.TIMEOUT_CYC(200)) dac_channel_sequencer_inst (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .bus_wr_in(bus_wr),
    .bus_rd_in(bus_rd), .bus_rd_cmd_in(rd_cmd), .bus_fault_in(bus_fault),
    .bus_active_in(bus_active), .group_stop_in(group_stop), .link_clk_in(link_clk),
    .protocol_en_in(protocol_en), .pin_is_reset_in(pin_is_reset),
    .reset_pin_n_in(reset_pin_n), .nvm_cfg_in(nvm_cfg), .write_lock_in(write_lock),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .comm_fault_flag_out(fault),
    .booting_out(booting), .lock_active_out(lock_act), .ch_on_out(ch_on),
    .ch_code_out(ch_code));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Read answers are matched against the oldest note
  always @(negedge core_clk_in) begin
    if (rd_valid === 1'b1) begin
      if (rd_notes.size() == 0) chk(16'hxxxx, 16'h0000, "unexpected read");
      else chk(rd_data, rd_notes.pop_front(), "read data");
    end
  end

  // Hang guard, well above the expected run
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      $display("MISMATCH at %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic settle();
    repeat (3) @(negedge core_clk_in);
  endtask

  // Boot pulse must appear within 8 cycles, then last between 18 and 27 cycles
  task automatic boot_seen();
    int n;
    n = 0;
    while (booting !== 1'b1 && n < 8) begin
      @(negedge core_clk_in);
      n++;
    end
    chk(booting, 16'h0001, "boot start");
    n = 0;
    while (booting !== 1'b0 && n < 100) begin
      @(negedge core_clk_in);
      n++;
    end
    chk(16'(n >= 18 && n <= 27), 16'h0001, "boot length");
  endtask

  // Channel 0 back to its low code with no slew
  task automatic park();
    pm_host_model_inst.wr(8'hD1, 16'h0000);
    pm_host_model_inst.op(8'h00, 8'h94);
    settle();
    chk(16'(ch_code[0]), 16'h0100, "park");
  endtask

  // Record successive channel 0 codes and cycle gaps
  task automatic collect(input int nchg);
    logic [11:0] last;
    int n;
    seen.delete();
    gaps.delete();
    last = ch_code[0];
    n = 0;
    while (seen.size() < nchg && n < 30000) begin
      @(negedge core_clk_in);
      n++;
      if (ch_code[0] !== last) begin
        last = ch_code[0];
        seen.push_back(last);
        gaps.push_back(n);
        n = 0;
      end
    end
    chk(16'(seen.size()), 16'(nchg), "change count");
  endtask

  initial begin
    int bad, d, k;
    void'($urandom(28));
    nvm_cfg = '0;
    for (int c = 0; c < 4; c++) begin
      nvm_cfg[c].margin_lo = (c == 0) ? 12'h100 : 12'($urandom % 256);
      nvm_cfg[c].margin_hi = (c == 0) ? 12'h200 : 12'h300 + 12'($urandom % 1024);
    end
    repeat (16) @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    boot_seen();
    pm_host_model_inst.op(8'h00, 8'h80);
    settle();
    chk(ch_on, 16'h0000, "disabled");
    protocol_en = 1'b1;
    pm_host_model_inst.op(8'h02, 8'h80);
    settle();
    chk(ch_on, 16'h0004, "page 2 on");
    pm_host_model_inst.op(8'hFF, 8'h80);
    pm_host_model_inst.op(8'h01, 8'h00);
    settle();
    chk(ch_on, 16'h000D, "page 1 off");
    rd_notes.push_back({8'h00, dac_seq_pkg::PROTO_REV_DEFAULT});
    pm_host_model_inst.rd(8'h98);
    settle();
    chk(16'(rd_notes.size()), 16'h0000, "read answered");
    pm_host_model_inst.op(8'hFF, 8'hA4);
    settle();
    for (int c = 0; c < 4; c++)
      chk(16'(ch_code[c]), 16'(nvm_cfg[c].margin_hi), "margin high");
    $display("test commands done");
    bus_fault = 1'b1;
    @(negedge core_clk_in);
    bus_fault = 1'b0;
    settle();
    chk(fault, 16'h0001, "fault set");
    pm_host_model_inst.wr(8'h7E, 16'h0000);
    settle();
    chk(fault, 16'h0001, "fault kept");
    pm_host_model_inst.wr(8'h7E, 16'h0002);
    settle();
    chk(fault, 16'h0000, "fault cleared");
    pm_host_model_inst.frame(260, 1'b0);
    chk(fault, 16'h0000, "live link");
    pm_host_model_inst.frame(260, 1'b1);
    settle();
    chk(fault, 16'h0001, "link timeout");
    pm_host_model_inst.wr(8'h7E, 16'h0002);
    $display("test faults done");
    for (int s = 0; s < 8; s++) begin
      per = dac_seq_pkg::STEP_TIME_10NS[1 + s % 2] * dac_seq_pkg::CLK_MHZ / 100;
      park();
      pm_host_model_inst.wr(8'hD1, 16'(s << 4) | 16'(1 + s % 2));
      pm_host_model_inst.op(8'h00, 8'hA4);
      collect(3);
      chk(16'(seen[1] - seen[0]), 16'(dac_seq_pkg::STEP_SIZE[s]), "step");
      chk(16'(gaps[2]), 16'(per), "period");
    end
    per = dac_seq_pkg::STEP_TIME_10NS[1] * dac_seq_pkg::CLK_MHZ / 100;
    for (int w = 0; w < 3; w++) begin
      park();
      pm_host_model_inst.wr(8'hD1, 16'h2071 | 16'(w << 8));
      pm_host_model_inst.op(8'h00, 8'h80);
      collect(20);
      bad = 0;
      for (int i = 1; i < 20; i++) begin
        d = int'(seen[i]) - int'(seen[i-1]);
        if (gaps[i] != per || seen[i] < 12'h100 || seen[i] > 12'h200) bad++;
        if (w == 0 && d != 32 && d != -32) bad++;
        if (w == 1 && d != 32 && seen[i] != 12'h100) bad++;
        if (w == 2 && d != -32 && seen[i] != 12'h200) bad++;
      end
      chk(16'(bad), 16'h0000, "wave shape");
    end
    for (int p = 0; p < 4; p++) begin
      park();
      pm_host_model_inst.wr(8'hD1, 16'h2401 | 16'(p << 11));
      pm_host_model_inst.op(8'h00, 8'h80);
      collect(p == 0 ? 24 : 6);
      for (int i = 0; i < seen.size(); i++) begin
        k = (dac_seq_pkg::PHASE_IDX[p] + i) % 24;
        chk(16'(seen[i]), 16'(dac_seq_pkg::SINE_TAB[k]), "sine");
        if (i > 0) chk(16'(gaps[i]), 16'(per), "sine step");
      end
      if (p == 0) chk(16'(seen[6]), 16'h0E66, "peak");
      if (p == 0) chk(16'(seen[18]), 16'h019A, "trough");
    end
    pm_host_model_inst.wr(8'hD1, 16'h0000);
    $display("test waves done");
    pm_host_model_inst.op(8'hFF, 8'h00);
    write_lock = 1'b1;
    settle();
    chk(lock_act, 16'h0001, "lock on");
    pm_host_model_inst.op(8'hFF, 8'h80);
    settle();
    chk(ch_on, 16'h0000, "locked write");
    pm_host_model_inst.wr(8'hD0, 16'h0050);
    settle();
    chk(lock_act, 16'h0000, "unlocked");
    pm_host_model_inst.op(8'hFF, 8'h80);
    settle();
    chk(ch_on, 16'h000F, "after unlock");
    write_lock = 1'b0;
    settle();
    write_lock = 1'b1;
    settle();
    pm_host_model_inst.wr(8'hD0, 16'h000A);
    boot_seen();
    chk(ch_on, 16'h0000, "soft reset");
    write_lock = 1'b0;
    pin_is_reset = 1'b1;
    pm_host_model_inst.op(8'hFF, 8'h80);
    reset_pin_n = 1'b0;
    boot_seen();
    chk(ch_on, 16'h0000, "pin reset");
    pm_host_model_inst.op(8'hFF, 8'h80);
    reset_pin_n = 1'b1;
    repeat (8) @(negedge core_clk_in);
    chk(booting, 16'h0000, "rise ignored");
    chk(ch_on, 16'h000F, "still on");
    $display("test resets done");
    report_and_stop();
  end
endmodule
